/* File: common/afepel_consts.svh */
`ifndef AFEPEL_CONSTS_SVH
`define AFEPEL_CONSTS_SVH

// ==========================================================================
// Register byte offsets.
`define AFEPEL_OFS_PMASK 12'h000
`define AFEPEL_OFS_PSTAT 12'h004
`define AFEPEL_OFS_HPTHR 12'h008
`define AFEPEL_OFS_LPTHR 12'h00c
`define AFEPEL_OFS_IOCFG 12'h010
`define AFEPEL_OFS_IODAT 12'h014
`define AFEPEL_OFS_IOEDG 12'h018
`define AFEPEL_OFS_IOSTA 12'h01c
`define AFEPEL_OFS_SYSC 12'h020
`define AFEPEL_OFS_SYSS 12'h024
`define AFEPEL_OFS_MUXS 12'h028
`define AFEPEL_OFS_TBLK 12'h02c

// ==========================================================================
// Field positions and reset values.
`define AFEPEL_SYSC_WAKE_EN 0
`define AFEPEL_SYSC_HIB 1
`define AFEPEL_SYSC_INT2PE1 2
`define AFEPEL_SYSC_TWMASK 3
`define AFEPEL_RST_ZERO 32'h0000_0000
`define AFEPEL_RST_TBLK 32'h0000_03e8

// ==========================================================================
// Timing: long press of 8 s at 20 MHz.
`define AFEPEL_CLK_HZ 20000000
`define AFEPEL_LONG_PRESS_S 8
`define AFEPEL_LONG_PRESS_CYC (`AFEPEL_LONG_PRESS_S * `AFEPEL_CLK_HZ)

`endif

/* File: common/afepel_pkg.sv */
package afepel_pkg;
  typedef enum logic [1:0] {AFEPEL_T_OK, AFEPEL_T_HOT, AFEPEL_T_BLANK}
    afepel_temp_t;
endpackage : afepel_pkg

/* File: src/afepel_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afepel_consts.svh"

module afepel_top import afepel_pkg::*; #(
  parameter int NAMP = 3,
  parameter int NIO = 10,
  parameter int NDB = 7,
  parameter int LONG_PRESS_CYC = `AFEPEL_LONG_PRESS_CYC
) (
  input wire logic CLK_SYS, // System clock.
  input wire logic RST, // Synchronous reset, active high.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB enable.
  input wire logic PWRITE, // APB direction.
  input wire logic [11:0] PADDR, // APB address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready.
  output logic PSLVERR, // APB error.
  input wire logic [NAMP-1:0] HIGH_SPEED_PROTECTION_CMP, // Fast comparators.
  input wire logic [NAMP-1:0] LIMIT_PROTECTION_CMP, // Limit comparators.
  output logic [7:0] HIGH_SPEED_PROTECTION_DAC, // 8-bit threshold.
  output logic [9:0] LIMIT_PROTECTION_DAC, // 10-bit threshold.
  output logic MAIN_INTERRUPT, // Main interrupt.
  output logic SECOND_INTERRUPT, // Second interrupt.
  output logic PROTECTION_EVENT_ONE, // Event one to driver stage.
  output logic PROTECTION_EVENT_TWO, // Event two to driver stage.
  input wire logic [NIO-1:0] IO_IN, // Pin levels.
  output logic [NIO-1:0] IO_OUT, // Pin output value, always low.
  output logic [NIO-1:0] IO_OE_N, // Low pulls the pin down.
  input wire logic [NDB-1:0] DIGITAL_SIGNAL_MATRIX_IN, // Matrix lines in.
  output logic [NDB-1:0] DIGITAL_SIGNAL_MATRIX_OUT, // Matrix lines out.
  output logic [NDB-1:0] DIGITAL_SIGNAL_MATRIX_OE, // Matrix drive.
  input wire logic PUSH_BUTTON_INPUT_N, // Push button, active low.
  output logic PUSH_BUTTON_EVENT, // Button pressed level.
  output logic MCU_RESET, // Long-press reset pulse.
  output logic WAKE, // Wake pulse from hibernation.
  input wire logic TEMP_WARN_HOT, // Above 140 C.
  input wire logic TEMP_FAULT_HOT, // Above 170 C.
  output logic WARNING_INTERRUPT_LINE, // Masked warning.
  output logic SHUTDOWN, // Supplies and drivers off.
  output logic [3:0] FRONT_END_SELECTOR, // 16-to-1 select.
  output logic [2:0] POWER_MONITOR_SELECTOR, // 8-to-1 select.
  output logic [2:0] ADC_CHANNEL, // 8-channel select.
  input wire logic [2:0] ADC_HARDWARE_SEQUENCER_CH, // Sequencer channel.
  input wire logic ADC_HARDWARE_SEQUENCER_EN, // Sequencer owns select.
  output logic ANALOG_BUS_TWO_HP, // Route 8-bit value to bus two.
  output logic ANALOG_BUS_THREE_LP, // Route 10-bit value to bus three.
  output logic [11:0] ANALOG_SIGNAL_MATRIX_EN // Bus line enables.
);

  // ==========================================================================
  // Registers.
  logic [31:0] pmask, hpthr, lpthr, iocfg, iodat, ioedg, sysc, muxs, tblk;
  logic [7:0] edge_stat;
  logic [NIO-1:0] io_prev;
  logic pb_prev;
  logic [31:0] pb_cnt;
  logic [31:0] warn_cnt, fault_cnt;
  afepel_temp_t warn_st, fault_st;
  logic warn_stat;

  wire wr = PSEL && PENABLE && PWRITE;
  wire rd_setup = PSEL && !PENABLE;
  wire [NIO-1:0] io_pol = iocfg[NIO-1:0];
  wire [NIO-1:0] io_outmode = iocfg[NIO+9:10];
  wire [NIO-1:0] io_log = IO_IN ^ io_pol;
  wire [NIO-1:0] io_prev_log = io_prev ^ io_pol;

  function automatic logic [NIO-1:0] pin_source(input logic [31:0] cfg,
      input logic [31:0] dat, input logic [NDB-1:0] db);
    logic [NIO-1:0] r;
    r = '0;
    for (int i = 0; i < NIO; i++) begin
      r[i] = cfg[20+i] ? db[i % NDB] : dat[i];
    end
    return r;
  endfunction : pin_source

  // ==========================================================================
  // APB slave with zero wait states.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pmask <= `AFEPEL_RST_ZERO;
      hpthr <= `AFEPEL_RST_ZERO;
      lpthr <= `AFEPEL_RST_ZERO;
      iocfg <= `AFEPEL_RST_ZERO;
      iodat <= `AFEPEL_RST_ZERO;
      ioedg <= `AFEPEL_RST_ZERO;
      sysc <= `AFEPEL_RST_ZERO;
      muxs <= `AFEPEL_RST_ZERO;
      tblk <= `AFEPEL_RST_TBLK;
    end else if (wr) begin
      if (PADDR == `AFEPEL_OFS_PMASK) begin
        pmask <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_HPTHR) begin
        hpthr <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_LPTHR) begin
        lpthr <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_IOCFG) begin
        iocfg <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_IODAT) begin
        iodat <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_IOEDG) begin
        ioedg <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_SYSC) begin
        sysc <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_MUXS) begin
        muxs <= PWDATA;
      end else if (PADDR == `AFEPEL_OFS_TBLK) begin
        tblk <= PWDATA;
      end
    end else if (WAKE) begin
      sysc[`AFEPEL_SYSC_HIB] <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= rd_setup;
      PSLVERR <= rd_setup && PADDR > `AFEPEL_OFS_TBLK;
      if (!rd_setup || PWRITE) begin
        PRDATA <= 32'h0000_0000;
      end else if (PADDR == `AFEPEL_OFS_PMASK) begin
        PRDATA <= pmask;
      end else if (PADDR == `AFEPEL_OFS_PSTAT) begin
        PRDATA <= 32'(HIGH_SPEED_PROTECTION_CMP)
          | (32'(LIMIT_PROTECTION_CMP) << 8);
      end else if (PADDR == `AFEPEL_OFS_HPTHR) begin
        PRDATA <= hpthr;
      end else if (PADDR == `AFEPEL_OFS_LPTHR) begin
        PRDATA <= lpthr;
      end else if (PADDR == `AFEPEL_OFS_IOCFG) begin
        PRDATA <= iocfg;
      end else if (PADDR == `AFEPEL_OFS_IODAT) begin
        PRDATA <= iodat;
      end else if (PADDR == `AFEPEL_OFS_IOEDG) begin
        PRDATA <= ioedg;
      end else if (PADDR == `AFEPEL_OFS_IOSTA) begin
        PRDATA <= 32'(io_log) | (32'(edge_stat) << 16);
      end else if (PADDR == `AFEPEL_OFS_SYSC) begin
        PRDATA <= sysc;
      end else if (PADDR == `AFEPEL_OFS_SYSS) begin
        PRDATA <= {28'h0000000, SHUTDOWN, warn_stat, PUSH_BUTTON_EVENT,
          MAIN_INTERRUPT};
      end else if (PADDR == `AFEPEL_OFS_MUXS) begin
        PRDATA <= muxs;
      end else if (PADDR == `AFEPEL_OFS_TBLK) begin
        PRDATA <= tblk;
      end else begin
        PRDATA <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================================
  // Protection masking and events.
  wire [2*NAMP-1:0] pcmp = {LIMIT_PROTECTION_CMP, HIGH_SPEED_PROTECTION_CMP};
  wire second_interrupt_now = |edge_stat;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      MAIN_INTERRUPT <= 1'b0;
      PROTECTION_EVENT_ONE <= 1'b0;
      PROTECTION_EVENT_TWO <= 1'b0;
      SECOND_INTERRUPT <= 1'b0;
      HIGH_SPEED_PROTECTION_DAC <= 8'h00;
      LIMIT_PROTECTION_DAC <= 10'h000;
    end else begin
      MAIN_INTERRUPT <= |(pcmp & pmask[2*NAMP-1:0]);
      PROTECTION_EVENT_ONE <= |(pcmp & pmask[2*NAMP+7:8])
        || (second_interrupt_now && sysc[`AFEPEL_SYSC_INT2PE1]);
      PROTECTION_EVENT_TWO <= |(pcmp & pmask[2*NAMP+15:16]);
      SECOND_INTERRUPT <= second_interrupt_now;
      HIGH_SPEED_PROTECTION_DAC <= hpthr[7:0];
      LIMIT_PROTECTION_DAC <= lpthr[9:0];
    end
  end

  // ==========================================================================
  // Front-end I/O pins, edges and digital matrix.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      io_prev <= '1;
      edge_stat <= 8'h00;
      IO_OUT <= '0;
      IO_OE_N <= '1;
      DIGITAL_SIGNAL_MATRIX_OUT <= '0;
      DIGITAL_SIGNAL_MATRIX_OE <= '0;
    end else begin
      io_prev <= IO_IN;
      for (int i = 0; i < 4; i++) begin
        // A new edge wins over a software clear in the same cycle.
        edge_stat[i] <= (ioedg[i] && io_log[6+i] && !io_prev_log[6+i])
          || (ioedg[4+i] && !io_log[6+i] && io_prev_log[6+i])
          || (edge_stat[i] && !(wr && PADDR == `AFEPEL_OFS_IOSTA
          && PWDATA[16+i]));
        edge_stat[4+i] <= 1'b0;
      end
      IO_OUT <= '0;
      IO_OE_N <= ~(io_outmode & ~(pin_source(iocfg, iodat,
        DIGITAL_SIGNAL_MATRIX_IN) ^ io_pol));
      for (int d = 0; d < NDB; d++) begin
        DIGITAL_SIGNAL_MATRIX_OUT[d] <= iocfg[30] ? pcmp[d % (2*NAMP)]
          : io_log[d];
        DIGITAL_SIGNAL_MATRIX_OE[d] <= muxs[24+d];
      end
    end
  end

  // ==========================================================================
  // Push button: event, long-press reset and wake.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      pb_prev <= 1'b1;
      pb_cnt <= 32'h0000_0000;
      PUSH_BUTTON_EVENT <= 1'b0;
      MCU_RESET <= 1'b0;
      WAKE <= 1'b0;
    end else begin
      pb_prev <= IO_IN[6];
      PUSH_BUTTON_EVENT <= !PUSH_BUTTON_INPUT_N;
      if (PUSH_BUTTON_INPUT_N || sysc[`AFEPEL_SYSC_HIB]) begin
        pb_cnt <= 32'h0000_0000;
      end else if (pb_cnt < 32'(LONG_PRESS_CYC)) begin
        pb_cnt <= pb_cnt + 32'h1;
      end
      MCU_RESET <= pb_cnt == 32'(LONG_PRESS_CYC - 1);
      WAKE <= sysc[`AFEPEL_SYSC_HIB] && sysc[`AFEPEL_SYSC_WAKE_EN]
        && pb_prev && !IO_IN[6];
    end
  end

  // ==========================================================================
  // Temperature warning and shutdown with restartable blanking.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      warn_st <= AFEPEL_T_OK;
      fault_st <= AFEPEL_T_OK;
      warn_cnt <= 32'h0000_0000;
      fault_cnt <= 32'h0000_0000;
    end else begin
      case (warn_st)
        AFEPEL_T_OK: if (TEMP_WARN_HOT) warn_st <= AFEPEL_T_HOT;
        AFEPEL_T_HOT: if (!TEMP_WARN_HOT) begin
          warn_st <= AFEPEL_T_BLANK;
          warn_cnt <= 32'h0000_0000;
        end
        default: begin
          if (TEMP_WARN_HOT) begin
            warn_st <= AFEPEL_T_HOT;
          end else if (warn_cnt >= tblk) begin
            warn_st <= AFEPEL_T_OK;
          end else begin
            warn_cnt <= warn_cnt + 32'h1;
          end
        end
      endcase
      case (fault_st)
        AFEPEL_T_OK: if (TEMP_FAULT_HOT) fault_st <= AFEPEL_T_HOT;
        AFEPEL_T_HOT: if (!TEMP_FAULT_HOT) begin
          fault_st <= AFEPEL_T_BLANK;
          fault_cnt <= 32'h0000_0000;
        end
        default: begin
          if (TEMP_FAULT_HOT) begin
            fault_st <= AFEPEL_T_HOT;
          end else if (fault_cnt >= tblk) begin
            fault_st <= AFEPEL_T_OK;
          end else begin
            fault_cnt <= fault_cnt + 32'h1;
          end
        end
      endcase
    end
  end

  assign warn_stat = warn_st != AFEPEL_T_OK;

  // ==========================================================================
  // Selector and routing outputs.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      WARNING_INTERRUPT_LINE <= 1'b0;
      SHUTDOWN <= 1'b0;
      FRONT_END_SELECTOR <= 4'h0;
      POWER_MONITOR_SELECTOR <= 3'h0;
      ADC_CHANNEL <= 3'h0;
      ANALOG_BUS_TWO_HP <= 1'b0;
      ANALOG_BUS_THREE_LP <= 1'b0;
      ANALOG_SIGNAL_MATRIX_EN <= 12'h000;
    end else begin
      WARNING_INTERRUPT_LINE <= warn_stat && sysc[`AFEPEL_SYSC_TWMASK];
      SHUTDOWN <= fault_st != AFEPEL_T_OK;
      FRONT_END_SELECTOR <= muxs[3:0];
      POWER_MONITOR_SELECTOR <= muxs[6:4];
      ADC_CHANNEL <= ADC_HARDWARE_SEQUENCER_EN ? ADC_HARDWARE_SEQUENCER_CH
        : muxs[10:8];
      ANALOG_BUS_TWO_HP <= muxs[11];
      ANALOG_BUS_THREE_LP <= muxs[12];
      ANALOG_SIGNAL_MATRIX_EN <= {muxs[23:13], 1'b0} | {9'h000,
        muxs[12], muxs[11], 1'b0};
    end
  end

  // ==========================================================================
  // Checks.
  a_event_two_mask: assert property (@(posedge CLK_SYS) disable iff (RST)
    PROTECTION_EVENT_TWO |-> $past(|(pcmp & pmask[2*NAMP+15:16])))
    else $error("event two without unmasked source");
  a_main_int_mask: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(pmask[2*NAMP-1:0] == '0) |-> !MAIN_INTERRUPT)
    else $error("main interrupt despite full mask");
  a_wake_needs_enable: assert property (@(posedge CLK_SYS) disable iff (RST)
    WAKE |-> $past(sysc[`AFEPEL_SYSC_WAKE_EN]))
    else $error("wake without enable");
  a_long_press: assert property (@(posedge CLK_SYS) disable iff (RST)
    MCU_RESET |-> $past(!PUSH_BUTTON_INPUT_N, 2))
    else $error("reset without held button");
  a_button_event: assert property (@(posedge CLK_SYS) disable iff (RST)
    PUSH_BUTTON_EVENT == $past(!PUSH_BUTTON_INPUT_N))
    else $error("button event mismatch");
  a_shutdown_hot: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(TEMP_FAULT_HOT, 2) |-> SHUTDOWN)
    else $error("no shutdown when hot");
  a_warn_hold: assert property (@(posedge CLK_SYS) disable iff (RST)
    $fell(TEMP_WARN_HOT) |=> warn_stat)
    else $error("warning cleared before blanking");
  a_adc_seq: assert property (@(posedge CLK_SYS) disable iff (RST)
    $past(ADC_HARDWARE_SEQUENCER_EN) |->
    ADC_CHANNEL == $past(ADC_HARDWARE_SEQUENCER_CH))
    else $error("sequencer channel ignored");
  c_event_one: cover property (@(posedge CLK_SYS) PROTECTION_EVENT_ONE);
  c_wake: cover property (@(posedge CLK_SYS) WAKE);
  c_shutdown_end: cover property (@(posedge CLK_SYS) $fell(SHUTDOWN));

endmodule : afepel_top
`default_nettype wire

/* File: tb/afepel_pins_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ==========================================================================
// Pins with pull-ups, outside switches and the gate-driver trip latch.
module afepel_pins_model (
  input wire logic clk, // Clock.
  input wire logic rst, // Synchronous reset.
  input wire logic [9:0] oe_n, // Device pulls the pin low when clear.
  input wire logic [9:0] ext_low, // Outside switch to ground.
  input wire logic pe_one, // Protection event one.
  input wire logic pe_two, // Protection event two.
  output logic [9:0] pin, // Resolved pin level.
  output logic tripped // Driver stage latched off.
);
  // Open drain with pull-up: whoever pulls low wins.
  assign pin = oe_n & ~ext_low;
  // Switches go off with no software step; only reset rearms.
  always_ff @(posedge clk) begin
    if (rst) begin
      tripped <= 1'b0;
    end else if (pe_one || pe_two) begin
      tripped <= 1'b1;
    end
  end
endmodule : afepel_pins_model
`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
`include "afepel_consts.svh"
module testbench;
  logic clk, rst, psel, penable, pwrite, er, pbn, warn, fault, seq_en;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd, seed, v, prdata;
  logic [2:0] hs, lp, seq_ch, pm_sel, adc_ch;
  logic [6:0] dsm_in, dsm_out, dsm_oe;
  logic [9:0] ext_low, io_out, io_oe_n, pin, lp_dac;
  logic [7:0] hs_dac;
  logic [3:0] fe_sel;
  logic [11:0] asm_en;
  logic pready, pslverr, main_irq, sec_irq, pe1, pe2, pb_evt, mcu_rst;
  logic wake, warn_line, shut, ab2, ab3, tripped, seen;
  int fail_count, checks_done, cyc, n;
  // ========================================================================
  // Device and its surroundings.
  afepel_top #(.LONG_PRESS_CYC(20)) afepel_top_inst (.CLK_SYS(clk),
    .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .HIGH_SPEED_PROTECTION_CMP(hs),
    .LIMIT_PROTECTION_CMP(lp), .HIGH_SPEED_PROTECTION_DAC(hs_dac),
    .LIMIT_PROTECTION_DAC(lp_dac), .MAIN_INTERRUPT(main_irq),
    .SECOND_INTERRUPT(sec_irq), .PROTECTION_EVENT_ONE(pe1),
    .PROTECTION_EVENT_TWO(pe2), .IO_IN(pin), .IO_OUT(io_out),
    .IO_OE_N(io_oe_n), .DIGITAL_SIGNAL_MATRIX_IN(dsm_in),
    .DIGITAL_SIGNAL_MATRIX_OUT(dsm_out), .DIGITAL_SIGNAL_MATRIX_OE(dsm_oe),
    .PUSH_BUTTON_INPUT_N(pbn), .PUSH_BUTTON_EVENT(pb_evt),
    .MCU_RESET(mcu_rst), .WAKE(wake), .TEMP_WARN_HOT(warn),
    .TEMP_FAULT_HOT(fault), .WARNING_INTERRUPT_LINE(warn_line),
    .SHUTDOWN(shut), .FRONT_END_SELECTOR(fe_sel),
    .POWER_MONITOR_SELECTOR(pm_sel), .ADC_CHANNEL(adc_ch),
    .ADC_HARDWARE_SEQUENCER_CH(seq_ch), .ADC_HARDWARE_SEQUENCER_EN(seq_en),
    .ANALOG_BUS_TWO_HP(ab2), .ANALOG_BUS_THREE_LP(ab3),
    .ANALOG_SIGNAL_MATRIX_EN(asm_en));
  afepel_pins_model afepel_pins_model_inst (.clk(clk), .rst(rst),
    .oe_n(io_oe_n), .ext_low(ext_low), .pe_one(pe1), .pe_two(pe2),
    .pin(pin), .tripped(tripped));
  // ========================================================================
  // Helpers.
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, s);
    checks_done++;
    if (s !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      fail_count++;
    end
  endtask : chk
  // One transfer; request held until pready is seen high at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      fail_count++;
    end
    @(posedge clk);
  endtask : apb
  task report_and_stop;
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  // ========================================================================
  // Clock, time limit and stimulus.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, hs, lp, warn, fault} = '0;
    {seq_en, seq_ch, ext_low, seen} = '0;
    rst = 1'b1;
    pbn = 1'b1;
    seed = 32'd3501;
    dsm_in = 7'h55;
    tick(16);
    rst <= 1'b0;
    @(posedge clk);
    chk("oe_n reset", 10'h3ff, io_oe_n);
    apb(0, `AFEPEL_OFS_PMASK, 0); chk("pmask reset", 0, rd);
    apb(0, `AFEPEL_OFS_TBLK, 0); chk("tblk reset", 32'h3e8, rd);
    apb(0, 12'h030, 0); chk("unmapped", 32'h1, {rd[30:0], er});
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed); v = seed;
      apb(1, `AFEPEL_OFS_PMASK, v);
      hs <= v[26:24]; lp <= v[29:27]; dsm_in <= v[6:0];
      tick(3);
      chk("main", (|(v[2:0] & v[26:24])) | (|(v[5:3] & v[29:27])), main_irq);
      chk("pe1", (|(v[10:8] & v[26:24])) | (|(v[13:11] & v[29:27])), pe1);
      chk("pe2", (|(v[18:16] & v[26:24])) | (|(v[21:19] & v[29:27])), pe2);
      seen = seen | pe1 | pe2;
      apb(0, `AFEPEL_OFS_PSTAT, 0);
      chk("pstat", {v[29:27], 5'h0, v[26:24]}, rd[10:0]);
      apb(1, `AFEPEL_OFS_HPTHR, v); apb(1, `AFEPEL_OFS_LPTHR, ~v); tick(2);
      chk("dacs", {v[7:0], ~v[9:0]}, {hs_dac, lp_dac});
      seq_en <= v[31]; seq_ch <= v[15:13];
      apb(1, `AFEPEL_OFS_MUXS, v); tick(2);
      chk("fe pm", {v[3:0], v[6:4]}, {fe_sel, pm_sel});
      chk("adc", v[31] ? v[15:13] : v[10:8], adc_ch);
      chk("buses", {v[12:11], v[23:13] | {9'h000, v[12:11]}},
        {ab3, ab2, asm_en[11:1]});
      chk("dsm oe", v[30:24], dsm_oe);
      hs <= 0; lp <= 0;
    end
    chk("trip", seen, tripped);
    hs <= 0; lp <= 0;
    apb(1, `AFEPEL_OFS_PMASK, 0);
    for (int d = 0; d < 4; d++) begin
      apb(1, `AFEPEL_OFS_IOCFG, 32'h400 | (d >> 1));
      apb(1, `AFEPEL_OFS_IODAT, d & 1); tick(2);
      chk("od pin0", d[0] ^ d[1], io_oe_n[0]);
      chk("io out", 0, io_out);
    end
    apb(1, `AFEPEL_OFS_IOCFG, 0);
    apb(1, `AFEPEL_OFS_IOEDG, 32'h2);
    ext_low <= 10'h080; tick(4);
    chk("fall masked", 0, sec_irq);
    chk("dsm out", 7'h7f, dsm_out);
    ext_low <= 0; tick(4);
    chk("rise second_interrupt", 1, sec_irq);
    apb(1, `AFEPEL_OFS_IOSTA, 32'h20000); tick(3);
    chk("second_interrupt clear", 0, sec_irq);
    apb(1, `AFEPEL_OFS_SYSC, 32'h4);
    ext_low <= 10'h080; tick(2); ext_low <= 0; tick(4);
    chk("second_interrupt to pe1", 1, pe1);
    apb(1, `AFEPEL_OFS_IOSTA, 32'h20000);
    apb(1, `AFEPEL_OFS_SYSC, 32'h3);
    ext_low <= 10'h040; n = 0;
    for (int k = 0; k < 10; k++) begin @(posedge clk); n += (wake === 1'b1); end
    chk("wake pulses", 1, n);
    ext_low <= 0;
    apb(0, `AFEPEL_OFS_SYSC, 0); chk("hib cleared", 0, rd[1]);
    pbn <= 1'b0; n = 0;
    for (int k = 0; k < 40; k++) begin @(posedge clk); n += (mcu_rst === 1'b1); end
    chk("long press", 1, n);
    chk("button evt", 1, pb_evt);
    pbn <= 1'b1;
    apb(1, `AFEPEL_OFS_TBLK, 4); apb(1, `AFEPEL_OFS_SYSC, 32'h8);
    warn <= 1'b1; tick(3);
    chk("warn on", 1, warn_line);
    warn <= 1'b0; tick(2); warn <= 1'b1; @(posedge clk); warn <= 1'b0; tick(4);
    chk("blank restart", 1, warn_line);
    tick(6);
    chk("warn off", 0, warn_line);
    fault <= 1'b1; tick(3);
    chk("shutdown", 1, shut);
    fault <= 1'b0; tick(12);
    chk("restart", 0, shut);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
